// ### common/rsi_defines.svh
// Constants of the reset state initializer: word indices, reset values, timing.
// Assumes byte addressing on the register bus, one 32-bit word per index.
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH
// Own control and status words
`define RSI_IDX_STATUS 6'h00
`define RSI_IDX_PC 6'h01
`define RSI_IDX_CTRL 6'h02
// Initialized register file, first and last index
`define RSI_IDX_FIRST 6'h08
`define RSI_IDX_PSW 6'h08
`define RSI_IDX_LATCH 6'h09
`define RSI_IDX_DIR 6'h0E
`define RSI_IDX_PULLUP 6'h13
`define RSI_IDX_PCC 6'h16
`define RSI_IDX_SUBOSCILLATOR_MODE 6'h17
`define RSI_IDX_CSS 6'h18
`define RSI_IDX_OSC_SETTLE_SELECT 6'h19
`define RSI_IDX_TMA_CNT 6'h1A
`define RSI_IDX_TMB_CNT 6'h1B
`define RSI_IDX_CMP 6'h1C
`define RSI_IDX_TMC 6'h1F
`define RSI_IDX_WTM 6'h21
`define RSI_IDX_WATCHDOG_CLOCK_SELECT 6'h22
`define RSI_IDX_WATCHDOG_MODE_REG 6'h23
`define RSI_IDX_SER 6'h24
`define RSI_IDX_TXS 6'h29
`define RSI_IDX_RXB 6'h2A
`define RSI_IDX_LCD 6'h2B
`define RSI_IDX_IRQF 6'h2E
`define RSI_IDX_IRQM 6'h30
`define RSI_IDX_EXTM 6'h32
`define RSI_IDX_KRM 6'h34
`define RSI_IDX_LAST 6'h34
// Reset values
`define RSI_RST_CLEAR 8'h00
`define RSI_RST_PSW 8'h02
`define RSI_RST_INPUT 8'hFF
`define RSI_RST_PCC 8'h02
`define RSI_RST_OSC_SETTLE_SELECT 8'h04
`define RSI_RST_TXS 8'hFF
`define RSI_RST_MASK 8'hFF
`define RSI_RST_PC 16'h0000
// Crystal or ceramic variant carries the settle select register
`define RSI_HAS_OSC_SETTLE_SELECT 1'b1
// Reset vector locations
`define RSI_VEC_LO_ADDR 16'h0000
`define RSI_VEC_HI_ADDR 16'h0001
// Status word bit positions and control bit
`define RSI_ST_RUN 0
`define RSI_ST_WDT 1
`define RSI_ST_PIN 2
`define RSI_ST_RAM 3
`define RSI_ST_LEVEL 4
`define RSI_CTRL_STANDBY 0
// Timing
`define RSI_CLK_PERIOD_NS 10
`define RSI_SETTLE_TIME_NS 6550000
`define RSI_CNT_W 20
`endif

// ### common/rsi_pkg.sv
// Types of the reset state initializer.
// Used with full package scope, never imported.
package rsi_pkg;
  typedef enum logic [2:0] {
    RSI_HOLD = 3'h0,
    RSI_SETTLE = 3'h1,
    RSI_FETCH_LO = 3'h2,
    RSI_FETCH_HI = 3'h3,
    RSI_FETCH_END = 3'h4,
    RSI_RUN = 3'h5
  } rsi_state_e;
  typedef logic [7:0] rsi_byte_t;
  typedef logic [5:0] rsi_idx_t;
endpackage : rsi_pkg

// ### rtl/rsi_sync.sv
// Two-stage level synchronizer with clock enable.
// Assumes the input is asynchronous to clock; output is the second stage.
`timescale 1ns/100ps
module rsi_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  // Both stages clear to the asserted-reset level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rsi_sync

// ### rtl/rsi_top.sv
// Reset state initializer: reset sources, settle wait, vector fetch, register file.
// Assumes a one-cycle synchronous program ROM and an Avalon-MM master on clock.
//
// Functional notes
// - PC is loaded from the two vector bytes at program addresses 0 and 1.
// - Status word resets to 02H.
// - RAM undefined at power-on; kept when reset arrives from standby.
// - All port output latches clear to 00H.
// - All port direction registers set to FFH, pins start as inputs.
// - All pull-up enable registers clear to 00H.
// - CPU clock control resets to 02H.
// - Suboscillator mode and subclock control clear to 00H.
// - Settle select resets to 04H, present only in the crystal variant.
// - Byte timer counters and modes clear; compares stay untouched.
// - Watch timer mode clears to 00H.
// - Watchdog clock select and mode clear to 00H.
// - Serial modes, status, baud clear; shifter FFH; receive holding untouched.
// - LCD mode, clock and boost registers clear to 00H.
// - Request flags clear to 00H, mask flags set to FFH.
// - External edge modes and key return mode clear to 00H.
// - During reset and settle wait everything but PC stays at reset state.
// - Reset pin low or watchdog overflow both enter the same reset.
// - After pin release the settle time elapses before execution.
// - Watchdog reset releases itself, then waits the settle time.
// - Pins are not driven during reset and the settle wait.
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "rsi_defines.svh"
module rsi_top #(
  parameter int SETTLE_CYCLES = `RSI_SETTLE_TIME_NS / `RSI_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic wdt_overflow,
  input wire logic [7:0] rom_data,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] rom_addr,
  output logic [15:0] pc_out,
  output logic cpu_run,
  output logic pin_drive_en,
  output logic ram_retained
);
  localparam logic [`RSI_CNT_W-1:0] SETTLE_LAST = `RSI_CNT_W'(SETTLE_CYCLES - 1);

  // Entry is implemented in the register file
  function automatic logic is_impl(input int i);
    if (i == int'(`RSI_IDX_OSC_SETTLE_SELECT)) begin
      return `RSI_HAS_OSC_SETTLE_SELECT;
    end
    return (i >= int'(`RSI_IDX_FIRST)) && (i <= int'(`RSI_IDX_LAST));
  endfunction : is_impl

  // Entry takes a value on reset; compares and receive holding do not
  function automatic logic has_rst(input int i);
    if ((i >= int'(`RSI_IDX_CMP)) && (i < int'(`RSI_IDX_TMC))) begin
      return 1'b0;
    end
    return i != int'(`RSI_IDX_RXB);
  endfunction : has_rst

  // Reset value per entry
  function automatic rsi_pkg::rsi_byte_t rst_val(input int i);
    if (i == int'(`RSI_IDX_PSW)) begin
      return `RSI_RST_PSW;
    end
    if ((i >= int'(`RSI_IDX_DIR)) && (i < int'(`RSI_IDX_PULLUP))) begin
      return `RSI_RST_INPUT;
    end
    if (i == int'(`RSI_IDX_PCC)) begin
      return `RSI_RST_PCC;
    end
    if (i == int'(`RSI_IDX_OSC_SETTLE_SELECT)) begin
      return `RSI_RST_OSC_SETTLE_SELECT;
    end
    if (i == int'(`RSI_IDX_TXS)) begin
      return `RSI_RST_TXS;
    end
    if ((i >= int'(`RSI_IDX_IRQM)) && (i < int'(`RSI_IDX_EXTM))) begin
      return `RSI_RST_MASK;
    end
    // Latches, pull-ups, clocks, timers, serial, LCD, flags, edge modes
    return `RSI_RST_CLEAR;
  endfunction : rst_val

  rsi_pkg::rsi_state_e state_reg;
  rsi_pkg::rsi_state_e state_next;
  logic [`RSI_CNT_W-1:0] cnt_reg;
  logic [`RSI_CNT_W-1:0] cnt_next;
  logic [7:0] vec_lo_reg;
  logic standby_reg;
  logic cause_wdt_reg;
  logic cause_pin_reg;
  logic [15:0] rom_addr_next;
  logic pin_ok;
  logic [7:0] file_rd [0:63];
  logic [63:0] rst_match;

  // Reset pin enters through two flip-flops
  rsi_sync u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(reset_pin_n),
    .sync_out(pin_ok)
  );

  // Reset decode and bus decode
  wire reset_event = !pin_ok || wdt_overflow;
  wire force_rst = (state_reg == rsi_pkg::RSI_HOLD) || (state_reg == rsi_pkg::RSI_SETTLE);
  wire enter_hold = reset_event && (state_reg != rsi_pkg::RSI_HOLD);
  wire settle_done = cnt_reg == SETTLE_LAST;
  wire hiz_next = (state_next == rsi_pkg::RSI_HOLD) || (state_next == rsi_pkg::RSI_SETTLE);
  wire bus_req = avs_read || avs_write;
  wire wr_fire = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire wr_ok = wr_fire && !force_rst;
  wire [5:0] acc_idx = avs_address[7:2];
  wire all_rst = &rst_match;

  // Sequencer next state; a reset event overrides every state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rsi_pkg::RSI_HOLD: begin
        state_next = rsi_pkg::RSI_SETTLE;
      end
      rsi_pkg::RSI_SETTLE: begin
        if (settle_done) begin
          state_next = rsi_pkg::RSI_FETCH_LO;
        end
      end
      rsi_pkg::RSI_FETCH_LO: begin
        state_next = rsi_pkg::RSI_FETCH_HI;
      end
      rsi_pkg::RSI_FETCH_HI: begin
        state_next = rsi_pkg::RSI_FETCH_END;
      end
      rsi_pkg::RSI_FETCH_END: begin
        state_next = rsi_pkg::RSI_RUN;
      end
      rsi_pkg::RSI_RUN: begin
        state_next = rsi_pkg::RSI_RUN;
      end
      default: begin
        state_next = rsi_pkg::RSI_HOLD;
      end
    endcase
    if (reset_event) begin
      state_next = rsi_pkg::RSI_HOLD;
    end
  end

  // Settle counter and vector address selection
  assign cnt_next = (state_reg == rsi_pkg::RSI_SETTLE) ? cnt_reg + 1'b1 : '0;
  assign rom_addr_next = (state_next == rsi_pkg::RSI_FETCH_LO) ? `RSI_VEC_LO_ADDR :
                         (state_next == rsi_pkg::RSI_FETCH_HI) ? `RSI_VEC_HI_ADDR : rom_addr;

  // Sequencer state, counter and pin release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= rsi_pkg::RSI_HOLD;
      cnt_reg <= '0;
      pin_drive_en <= 1'b0;
      cpu_run <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pin_drive_en <= !hiz_next;
      cpu_run <= state_next == rsi_pkg::RSI_RUN;
    end
  end

  // Vector fetch into the program counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rom_addr <= `RSI_VEC_LO_ADDR;
      vec_lo_reg <= `RSI_RST_CLEAR;
      pc_out <= `RSI_RST_PC;
    end else if (clk_en) begin
      rom_addr <= rom_addr_next;
      if (state_reg == rsi_pkg::RSI_FETCH_HI) begin
        vec_lo_reg <= rom_data;
      end
      if (state_reg == rsi_pkg::RSI_FETCH_END) begin
        pc_out <= {rom_data, vec_lo_reg};
      end
    end
  end

  // Cause, standby and RAM retention; reset entry beats a standby write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      standby_reg <= 1'b0;
      ram_retained <= 1'b0;
      cause_wdt_reg <= 1'b0;
      cause_pin_reg <= 1'b0;
    end else if (clk_en) begin
      if (enter_hold) begin
        ram_retained <= standby_reg;
        standby_reg <= 1'b0;
        cause_wdt_reg <= wdt_overflow;
        cause_pin_reg <= !pin_ok;
      end else if (wr_ok && (acc_idx == `RSI_IDX_CTRL)) begin
        standby_reg <= avs_writedata[`RSI_CTRL_STANDBY];
      end
    end
  end

  // Register file, one byte per entry
  for (genvar gi = 0; gi < 64; gi++) begin : g_file
    if (is_impl(gi)) begin : g_impl
      logic [7:0] q_reg;
      wire we = wr_ok && (acc_idx == 6'(gi));
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          q_reg <= rst_val(gi);
        end else if (clk_en) begin
          if (force_rst && has_rst(gi)) begin
            q_reg <= rst_val(gi);
          end else if (we) begin
            q_reg <= avs_writedata[7:0];
          end
        end
      end
      assign file_rd[gi] = q_reg;
      assign rst_match[gi] = !has_rst(gi) || (q_reg == rst_val(gi));
    end else begin : g_none
      assign file_rd[gi] = 8'h00;
      assign rst_match[gi] = 1'b1;
    end
  end

  // Read word selection
  wire [4:0] status_bits = {pin_ok, ram_retained, cause_pin_reg, cause_wdt_reg, cpu_run};
  wire [31:0] rd_word = (acc_idx == `RSI_IDX_STATUS) ? {27'h000_0000, status_bits} :
                        (acc_idx == `RSI_IDX_PC) ? {16'h0000, pc_out} :
                        (acc_idx == `RSI_IDX_CTRL) ? {31'h0000_0000, standby_reg} :
                        {24'h00_0000, file_rd[acc_idx]};

  // Bus slave: one wait cycle, then a one-cycle answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_word;
      end
    end
  end

  // Reset hold keeps every initialized register at its reset value
  hold_regs_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    force_rst && clk_en |=> all_rst
  ) else $error("register left reset state during hold");

  // Pins undriven exactly while holding or settling
  pin_hiz_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    pin_drive_en == !force_rst
  ) else $error("pin drive does not match reset phase");

  // Watchdog overflow enters reset on the next edge
  wdt_enter_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wdt_overflow && clk_en |=> (state_reg == rsi_pkg::RSI_HOLD) && !cpu_run
  ) else $error("watchdog overflow did not reset");

  // Hold releases by itself once no source is active
  self_release_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_reg == rsi_pkg::RSI_HOLD) && !reset_event && clk_en |=> state_reg == rsi_pkg::RSI_SETTLE
  ) else $error("hold did not release into settle");

  // Settle holds until the full count has run
  settle_len_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_reg == rsi_pkg::RSI_SETTLE) && (cnt_reg != SETTLE_LAST) && !reset_event && clk_en
    |=> state_reg == rsi_pkg::RSI_SETTLE
  ) else $error("settle ended early");

  // Pin low reaches hold after two synchronizer stages
  pin_enter_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !reset_pin_n && clk_en ##1 clk_en ##1 clk_en |=> state_reg == rsi_pkg::RSI_HOLD
  ) else $error("pin reset not applied after sync");

  // Program counter takes both vector bytes
  pc_load_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_reg == rsi_pkg::RSI_FETCH_END) && !reset_event && clk_en
    |=> cpu_run && (pc_out == {$past(rom_data), $past(vec_lo_reg)})
  ) else $error("program counter not loaded from vector");

  // Standby reset keeps RAM, other entries do not
  ram_keep_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    enter_hold && clk_en |=> ram_retained == $past(standby_reg)
  ) else $error("RAM retention flag wrong");

  // Status word resets to its value during hold
  psw_rst_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    force_rst && clk_en |=> g_file[8].g_impl.q_reg == `RSI_RST_PSW
  ) else $error("status word not at reset value");

  // Bus answers one cycle after the request appears
  bus_ack_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus_req && avs_waitrequest && clk_en |=> !avs_waitrequest
  ) else $error("bus answer late");

  // Standby request is dropped on every reset entry
  standby_clr_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    enter_hold && clk_en |=> !standby_reg
  ) else $error("standby not cleared on reset entry");

  // Watchdog entry is recorded as the cause
  wdt_cause_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    enter_hold && wdt_overflow && clk_en |=> cause_wdt_reg
  ) else $error("watchdog cause not recorded");

  // Mask flags sit at all ones during hold
  mask_rst_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    force_rst && clk_en |=> (g_file[48].g_impl.q_reg == `RSI_RST_MASK) &&
    (g_file[49].g_impl.q_reg == `RSI_RST_MASK)
  ) else $error("mask flags not at reset value");

  // High vector byte is addressed during the high fetch
  vec_addr_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_reg == rsi_pkg::RSI_FETCH_HI |-> rom_addr == `RSI_VEC_HI_ADDR
  ) else $error("vector high address not presented");

  // Clock enable low freezes the sequencer
  clk_freeze_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(state_reg) && $stable(cnt_reg) && $stable(pc_out)
  ) else $error("state moved while clock enable low");
endmodule : rsi_top

// ### dv/rsi_reset_src.sv
// External reset circuit model driving the active-low reset pin.
// Assumes the bench requests a pulse with go for one cycle on clock.
`timescale 1ns/100ps
module rsi_reset_src (
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] low_cycles,
  output logic reset_pin_n
);
  logic [7:0] cnt_reg;
  initial begin
    reset_pin_n = 1'b1;
    cnt_reg = 8'h00;
  end
  // Holds the pin low for one cycle more than the requested count, then lets it go high
  always @(posedge clock) begin
    if (go) begin
      reset_pin_n <= 1'b0;
      cnt_reg <= low_cycles;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end else begin
      reset_pin_n <= 1'b1;
    end
  end
endmodule : rsi_reset_src

// ### dv/tb_reset_state_initializer.sv
// Self-checking bench of the reset state initializer.
// Assumes rsi_top with a short settle count; bench plays ROM and bus master.
`timescale 1ns/100ps
`include "rsi_defines.svh"
module tb_reset_state_initializer;
  localparam int SETTLE = 8;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wdt_overflow = 1'b0, go = 1'b0;
  logic reset_pin_n, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic cpu_run, pin_drive_en, ram_retained;
  logic [7:0] rom_data = 8'h00, avs_address = 8'h00, vec_lo, vec_hi;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic [15:0] rom_addr, pc_out;
  logic [7:0] shadow [64];
  logic [31:0] exp_q [$];
  int err_count = 0, comparisons = 0, n;
  logic [7:0] d;
  rsi_reset_src u_src (.clock(clock), .go(go), .low_cycles(8'h14), .reset_pin_n(reset_pin_n));
  rsi_top #(.SETTLE_CYCLES(SETTLE)) DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .reset_pin_n(reset_pin_n), .wdt_overflow(wdt_overflow), .rom_data(rom_data),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr), .pc_out(pc_out), .cpu_run(cpu_run),
    .pin_drive_en(pin_drive_en), .ram_retained(ram_retained));
  // Clock
  always #5 clock = ~clock;
  // Program ROM, one cycle latency; other addresses toggle
  always @(posedge clock) begin
    rom_data <= (rom_addr === 16'h0000) ? vec_lo : (rom_addr === 16'h0001) ? vec_hi : ~rom_data;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0 && exp_q.size() == 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // Read answers are compared against the oldest note
  always @(posedge clock) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check(avs_readdata, exp_q.pop_front());
    end
  end
  // Holds a request until waitrequest is sampled low
  task automatic bus_wait;
    int k;
    k = 0;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clock);
      k++;
    end
    if (k >= 50) err_count++;
  endtask : bus_wait
  task automatic bus_write(input logic [5:0] idx, input logic [7:0] v, input logic [3:0] be);
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, v};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [5:0] idx, input logic [31:0] expv);
    @(posedge clock);
    exp_q.push_back(expv);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    bus_wait();
    avs_read <= 1'b0;
  endtask : bus_read
  function automatic logic [7:0] rst_val(input int i);
    if (i == 8) return `RSI_RST_PSW;
    if (i == 22) return `RSI_RST_PCC;
    if (i >= 14 && i <= 18) return `RSI_RST_INPUT;
    if (i == 41) return `RSI_RST_TXS;
    if (i == 48 || i == 49) return `RSI_RST_MASK;
    if (i == 25) return `RSI_RST_OSC_SETTLE_SELECT;
    if ((i >= 28 && i <= 30) || i == 42) return shadow[i];
    return `RSI_RST_CLEAR;
  endfunction : rst_val
  // Whole register file against its reset state
  task automatic check_all;
    for (int i = 8; i <= 52; i++) bus_read(i[5:0], {24'h00_0000, rst_val(i)});
  endtask : check_all
  // Counts cycles to execution; pins checked undriven for the first SETTLE cycles of the wait
  task automatic wait_run(output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      cnt++;
      if (cnt <= SETTLE) check({31'h0, pin_drive_en}, 32'h0000_0000);
    end while (cpu_run !== 1'b1 && cnt < 300);
    check(32'(cnt >= SETTLE + 2 && cnt <= SETTLE + 7), 32'h0000_0001);
    check({16'h0000, pc_out}, {16'h0000, vec_hi, vec_lo});
    check({16'h0000, rom_addr}, {16'h0000, `RSI_VEC_HI_ADDR});
    check({31'h0, pin_drive_en}, 32'h0000_0001);
    bus_read(`RSI_IDX_PC, {16'h0000, vec_hi, vec_lo});
  endtask : wait_run
  // Watchdog
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    n = $urandom(98166);
    for (int i = 0; i < 64; i++) shadow[i] = 8'h00;
    vec_lo = $urandom;
    vec_hi = $urandom;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    wait_run(n);
    check_all();
    bus_read(6'h03, 32'h0000_0000);
    bus_read(6'h35, 32'h0000_0000);
    for (int i = 8; i <= 52; i++) begin
      d = $urandom;
      bus_write(i[5:0], d, 4'hF);
      shadow[i] = d;
      bus_read(i[5:0], {24'h00_0000, d});
    end
    bus_write(`RSI_IDX_PSW, ~shadow[8], 4'hE);
    bus_read(`RSI_IDX_PSW, {24'h00_0000, shadow[8]});
    for (int c = 0; c < 2; c++) begin
      bus_write(`RSI_IDX_CTRL, (c == 0) ? 8'h01 : 8'h00, 4'hF);
      vec_lo = $urandom;
      vec_hi = $urandom;
      @(posedge clock);
      if (c == 0) begin
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (5) @(posedge clock);
        check({30'h0, cpu_run, pin_drive_en}, 32'h0000_0000);
        bus_write(`RSI_IDX_PSW, 8'h55, 4'hF);
        n = 0;
        while (reset_pin_n !== 1'b1 && n < 100) begin
          @(posedge clock);
          n++;
        end
      end else begin
        wdt_overflow <= 1'b1;
        @(posedge clock);
        wdt_overflow <= 1'b0;
      end
      wait_run(n);
      check({31'h0, ram_retained}, (c == 0) ? 32'h0000_0001 : 32'h0000_0000);
      check_all();
      bus_read(`RSI_IDX_STATUS, (c == 0) ? 32'h0000_001D : 32'h0000_0013);
      bus_read(`RSI_IDX_CTRL, 32'h0000_0000);
    end
    // Clock enable low freezes the sequencer against a watchdog overflow
    clk_en <= 1'b0;
    wdt_overflow <= 1'b1;
    repeat (4) @(posedge clock);
    check({30'h0, cpu_run, pin_drive_en}, 32'h0000_0003);
    clk_en <= 1'b1;
    wdt_overflow <= 1'b0;
    bus_read(`RSI_IDX_STATUS, 32'h0000_0013);
    repeat (5) @(posedge clock);
    complete_run();
  end
endmodule : tb_reset_state_initializer
